// ### rtl/dfc_pkg.sv
// shared constants, types and helpers of the decimating filter chain
package dfc_pkg;

    localparam int DFC_DW             = 24;   // data and coefficient width
    localparam int DFC_ACC_W          = 48;   // accumulator width
    localparam int DFC_FRAC           = 20;   // fraction bits, sign.3.20 format
    localparam int DFC_MAC_BLOCKS     = 36;
    localparam int DFC_TAPS_PER_BLOCK = 3;
    localparam int DFC_HB_STAGES      = 3;
    localparam int DFC_HB_TAPS        = 7;
    localparam int DFC_HB_SHIFT       = 5;    // half-band taps sum to 32
    localparam int DFC_HB_GUARD       = 6;    // headroom of the half-band sum
    localparam int DFC_SYNC_STAGES    = 3;
    localparam int DFC_TAP_AW         = 7;
    localparam int DFC_RATE_W         = 9;

    localparam logic [8:0]  DFC_MIN_RATE     = 9'h002;   // unavoidable decimate by two
    localparam logic [8:0]  DFC_MAX_RATE     = 9'h100;   // 256
    localparam logic [8:0]  DFC_SETTLE_EXTRA = 9'h004;   // preset fill, in postprocessor words
    localparam logic [23:0] DFC_MOD_POS      = 24'h100000; // +1.0
    localparam logic [23:0] DFC_MOD_NEG      = 24'hf00000; // -1.0
    localparam logic [23:0] DFC_DATA_RST     = 24'h000000;
    localparam logic [47:0] DFC_ACC_RST      = 48'h000000000000;
    localparam logic [7:0]  DFC_SEQ_RST      = 8'h00;
    localparam logic [8:0]  DFC_SETTLE_RST   = 9'h000;
    localparam logic [2:0]  DFC_SYNC_RST     = 3'h0;

    // postprocessor structure selection
    typedef enum logic [1:0] {
        DFC_MODE_FIR,
        DFC_MODE_IIR,
        DFC_MODE_POLY
    } dfc_mode_e;

    // filter sequencer states
    typedef enum logic [1:0] {
        SEQ_HOLD,
        SEQ_FILL,
        SEQ_RUN
    } dfc_seq_e;

    // one data word with its strobe
    typedef struct packed {
        logic                     valid;
        logic signed [DFC_DW-1:0] data;
    } dfc_word_s;

    // multiply and add in accumulator width
    function automatic logic signed [DFC_ACC_W-1:0] dfcMac(input logic signed [DFC_DW-1:0]    x,
                                                           input logic signed [DFC_DW-1:0]    c,
                                                           input logic signed [DFC_ACC_W-1:0] acc);
        return acc + (DFC_ACC_W'(x) * DFC_ACC_W'(c));
    endfunction

    // keep the rate factor within two and 256
    function automatic logic [8:0] dfcClampRate(input logic [8:0] f);
        return (f < DFC_MIN_RATE) ? DFC_MIN_RATE : ((f > DFC_MAX_RATE) ? DFC_MAX_RATE : f);
    endfunction

endpackage

// ### rtl/dfc_halfband.sv
// one half-band decimate-by-two FIR stage of the preset filter
module dfc_halfband import dfc_pkg::*; #(
    parameter int W = DFC_DW
) (
    input  wire logic      clk,
    input  wire logic      nrst,
    input  wire logic      phaseClr,
    input  wire dfc_word_s inWord,
    output dfc_word_s      outWord
);

    localparam int SW = W + DFC_HB_GUARD;

    logic signed [W-1:0] line_r [DFC_HB_TAPS];
    logic                phase_r;
    dfc_word_s           out_r;

    // taps -1 0 9 16 9 0 -1, newest sample enters at index 0
    wire logic signed [SW-1:0] x0  = SW'(inWord.data);
    wire logic signed [SW-1:0] x2  = SW'(line_r[1]);
    wire logic signed [SW-1:0] x3  = SW'(line_r[2]);
    wire logic signed [SW-1:0] x4  = SW'(line_r[3]);
    wire logic signed [SW-1:0] x6  = SW'(line_r[5]);
    wire logic signed [SW-1:0] sum = ((x2 + x4) <<< 3) + x2 + x4 + (x3 <<< 4) - x0 - x6;
    wire logic signed [SW-1:0] scl = sum >>> DFC_HB_SHIFT;

    // shift every word, emit on every second one; the even phase is skipped
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < DFC_HB_TAPS; i++) begin
                line_r[i] <= '0;
            end
            phase_r <= 1'b0;
            out_r   <= '0;
        end else begin
            out_r.valid <= inWord.valid & phase_r & ~phaseClr;
            if (inWord.valid) begin
                line_r[0] <= inWord.data;
                for (int i = 1; i < DFC_HB_TAPS; i++) begin
                    line_r[i] <= line_r[i-1];
                end
                out_r.data <= scl[W-1:0];
            end
            if (phaseClr) begin
                phase_r <= 1'b0;
            end else if (inWord.valid) begin
                phase_r <= ~phase_r;
            end
        end
    end

    assign outWord = out_r;

endmodule

// ### rtl/dfc_coef_mem.sv
// coefficient store of the postprocessor, all words read out in parallel
module dfc_coef_mem import dfc_pkg::*; #(
    parameter int DEPTH = DFC_MAC_BLOCKS * DFC_TAPS_PER_BLOCK,
    parameter int W     = DFC_DW,
    parameter int AW    = DFC_TAP_AW
) (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic               wrEn,
    input  wire logic [AW-1:0]      wrAddr,
    input  wire logic [W-1:0]       wrData,
    output logic      [DEPTH*W-1:0] coefAll
);

    logic [DEPTH*W-1:0] store_r;

    // every multiplier needs its word each cycle, so the store is the read register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            store_r <= '0;
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                if (wrEn && (32'(wrAddr) == i)) begin
                    store_r[i*W +: W] <= wrData;
                end
            end
        end
    end

    assign coefAll = store_r;

endmodule

// ### rtl/dfc_top.sv
// decimating filter chain: preset half-band stages, systolic postprocessor, sequencer
module dfc_top import dfc_pkg::*; #(
    parameter int MAC_BLOCKS     = DFC_MAC_BLOCKS,
    parameter int TAPS_PER_BLOCK = DFC_TAPS_PER_BLOCK
) (
    input  wire logic                     clk,
    input  wire logic                     nrst,
    input  wire logic                     modBit,
    input  wire logic                     alignPin,
    input  wire logic                     cfgStartPin,
    input  wire logic                     oscillatorBypass,
    input  wire logic                     coefWrEn,
    input  wire logic [DFC_TAP_AW-1:0]    coefWrAddr,
    input  wire logic [DFC_DW-1:0]        coefWrData,
    input  wire logic [DFC_TAP_AW-1:0]    tapCount,
    input  wire logic [DFC_RATE_W-1:0]    rateFactor,
    input  wire dfc_mode_e                postMode,
    input  wire logic [DFC_DW-1:0]        fbCoef,
    output dfc_word_s                     outWord,
    output logic                          outSettled,
    output logic                          oscEnable,
    output logic [7:0]                    seqCount
);

    localparam int TAPS = MAC_BLOCKS * TAPS_PER_BLOCK;
    localparam int DW   = DFC_DW;
    localparam int AW   = DFC_ACC_W;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    ////////////////////////////////////////////////////////////////////////////

    logic [DFC_SYNC_STAGES-1:0] alignSync_r;
    logic [DFC_SYNC_STAGES-1:0] initSync_r;
    logic [DFC_SYNC_STAGES-1:0] bypassSync_r;
    logic                       alignLvl_r;
    logic                       initLvl_r;
    logic                       initPrev_r;
    logic                       bypassLvl_r;
    logic                       oscEnable_r;

    // three flops per pin; a level is taken only when stages two and three agree.
    // exception: a one-clock alignment strobe never gives an agreeing pair, so a
    // rise seen at stage two sets the alignment level at once; this gives up a
    // little glitch immunity so that a single-cycle strobe from a controller lands
    always_ff @(posedge clk) begin
        if (!nrst) begin
            alignSync_r  <= DFC_SYNC_RST;
            initSync_r   <= DFC_SYNC_RST;
            bypassSync_r <= DFC_SYNC_RST;
            alignLvl_r   <= 1'b0;
            initLvl_r    <= 1'b0;
            initPrev_r   <= 1'b0;
            bypassLvl_r  <= 1'b0;
        end else begin
            alignSync_r  <= {alignSync_r[1:0], alignPin};
            initSync_r   <= {initSync_r[1:0], cfgStartPin};
            bypassSync_r <= {bypassSync_r[1:0], oscillatorBypass};
            if (alignSync_r[1] == alignSync_r[2]) begin
                alignLvl_r <= alignSync_r[2];
            end else if (alignSync_r[1]) begin
                alignLvl_r <= 1'b1;
            end
            if (initSync_r[1] == initSync_r[2]) begin
                initLvl_r <= initSync_r[2];
            end
            if (bypassSync_r[1] == bypassSync_r[2]) begin
                bypassLvl_r <= bypassSync_r[2];
            end
            initPrev_r <= initLvl_r;
        end
    end

    // configuration start aligns on its rising edge only, for one clock;
    // either source resets the sequencer and the half-band phases
    wire logic initRise   = initLvl_r & ~initPrev_r;
    wire logic alignHold  = alignLvl_r | initRise;

    // oscillator enable; the clock itself is assumed continuous once powered
    always_ff @(posedge clk) begin
        if (!nrst) begin
            oscEnable_r <= 1'b1;
        end else begin
            oscEnable_r <= ~bypassLvl_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // preset filter: three half-band decimators
    ////////////////////////////////////////////////////////////////////////////

    dfc_word_s presetIn;
    dfc_word_s hbChain [DFC_HB_STAGES+1];

    // one modulator word enters every master clock
    assign presetIn.valid = 1'b1;
    assign presetIn.data  = modBit ? DFC_MOD_POS : DFC_MOD_NEG;
    assign hbChain[0]     = presetIn;

    for (genvar g = 0; g < DFC_HB_STAGES; g++) begin : gHalfband
        dfc_halfband #(
            .W (DW)
        ) uStage (
            .clk      (clk),
            .nrst     (nrst),
            .phaseClr (alignHold),
            .inWord   (hbChain[g]),
            .outWord  (hbChain[g+1])
        );
    end

    // after three halvings a word arrives every eighth clock
    wire dfc_word_s preWord = hbChain[DFC_HB_STAGES];

    ////////////////////////////////////////////////////////////////////////////
    // coefficient store
    ////////////////////////////////////////////////////////////////////////////

    logic [TAPS*DW-1:0] coefAll;

    dfc_coef_mem #(
        .DEPTH (TAPS),
        .W     (DW),
        .AW    (DFC_TAP_AW)
    ) uCoef (
        .clk     (clk),
        .nrst    (nrst),
        .wrEn    (coefWrEn),
        .wrAddr  (coefWrAddr),
        .wrData  (coefWrData),
        .coefAll (coefAll)
    );

    ////////////////////////////////////////////////////////////////////////////
    // systolic array: transposed FIR, three taps per MAC block
    ////////////////////////////////////////////////////////////////////////////

    wire logic signed [AW-1:0] tapSum [TAPS+1];

    assign tapSum[TAPS] = DFC_ACC_RST;

    // each element only multiplies by its own coefficient and adds its right neighbour;
    // taps beyond tapCount see a zero coefficient, so unused tail just passes zeros;
    // limitation: lowering tapCount does not flush partial sums already in the chain,
    // they drain out after as many words as the old tap count
    for (genvar b = 0; b < MAC_BLOCKS; b++) begin : gMacBlock
        for (genvar j = 0; j < TAPS_PER_BLOCK; j++) begin : gTap
            localparam int K = b * TAPS_PER_BLOCK + j;
            logic signed [AW-1:0] acc_r;
            wire logic            tapOn = (32'(tapCount) > K);
            wire logic signed [DW-1:0] coefK = tapOn ? coefAll[K*DW +: DW] : DFC_DATA_RST;
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    acc_r <= DFC_ACC_RST;
                end else if (preWord.valid) begin
                    acc_r <= dfcMac(preWord.data, coefK, tapSum[K+1]);
                end
            end
            assign tapSum[K] = acc_r;
        end
    end

    logic firValid_r;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            firValid_r <= 1'b0;
        end else begin
            firValid_r <= preWord.valid;
        end
    end

    wire logic signed [DW-1:0] firData = tapSum[0][DFC_FRAC+DW-1:DFC_FRAC];

    ////////////////////////////////////////////////////////////////////////////
    // structure stage: plain FIR, first order recursion or square term
    ////////////////////////////////////////////////////////////////////////////

    logic signed [DW-1:0] yPrev_r;

    wire logic signed [AW-1:0] firSqAcc = dfcMac(firData, firData, DFC_ACC_RST);
    wire logic signed [DW-1:0] firSq    = firSqAcc[DFC_FRAC+DW-1:DFC_FRAC];
    wire logic signed [DW-1:0] fbSrc    = (postMode == DFC_MODE_POLY) ? firSq : yPrev_r;
    wire logic signed [AW-1:0] firBase  = AW'(firData) <<< DFC_FRAC;
    wire logic signed [AW-1:0] postAcc  = (postMode == DFC_MODE_FIR) ? firBase
                                          : dfcMac(fbSrc, fbCoef, firBase);
    wire logic signed [DW-1:0] postData = postAcc[DFC_FRAC+DW-1:DFC_FRAC];

    // recursion memory follows every filtered word, also before settling
    always_ff @(posedge clk) begin
        if (!nrst) begin
            yPrev_r <= DFC_DATA_RST;
        end else if (firValid_r) begin
            yPrev_r <= postData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // filter sequencer, rate change and settling
    ////////////////////////////////////////////////////////////////////////////

    dfc_seq_e        seqState_r;
    dfc_seq_e        seqState_nxt;
    logic [7:0]      rateCnt_r;
    logic [8:0]      settleCnt_r;
    dfc_word_s       outWord_r;
    logic            outSettled_r;

    wire logic [8:0] rateUse      = dfcClampRate(rateFactor);
    wire logic [7:0] rateLast     = 8'(rateUse - 9'h001);
    wire logic       rateHit      = (rateCnt_r == rateLast);
    wire logic [8:0] settleTarget = 9'(tapCount) + DFC_SETTLE_EXTRA;
    wire logic       settleDone   = (settleCnt_r >= settleTarget);
    wire logic       emitWord     = firValid_r & rateHit;

    // sequencer next state
    always_comb begin
        seqState_nxt = seqState_r;
        case (seqState_r)
            SEQ_HOLD: begin
                if (!alignHold) begin
                    seqState_nxt = SEQ_FILL;
                end
            end
            SEQ_FILL: begin
                if (alignHold) begin
                    seqState_nxt = SEQ_HOLD;
                end else if (settleDone) begin
                    seqState_nxt = SEQ_RUN;
                end
            end
            SEQ_RUN: begin
                if (alignHold) begin
                    seqState_nxt = SEQ_HOLD;
                end
            end
            default: begin
                seqState_nxt = SEQ_HOLD;
            end
        endcase
    end

    // sequencer count restarts at zero so all aligned devices emit together
    always_ff @(posedge clk) begin
        if (!nrst) begin
            seqState_r  <= SEQ_FILL;
            rateCnt_r   <= DFC_SEQ_RST;
            settleCnt_r <= DFC_SETTLE_RST;
        end else begin
            seqState_r <= seqState_nxt;
            if (alignHold) begin
                rateCnt_r   <= DFC_SEQ_RST;
                settleCnt_r <= DFC_SETTLE_RST;
            end else if (firValid_r) begin
                rateCnt_r <= rateHit ? DFC_SEQ_RST : 8'(rateCnt_r + 8'h01);
                if (!settleDone) begin
                    settleCnt_r <= 9'(settleCnt_r + 9'h001);
                end
            end
        end
    end

    // a word leaves only when settled and not aligning; data moves only with it,
    // so a reader never sees the held word change between strobes
    wire logic wordOut = emitWord & ~alignHold & (seqState_r == SEQ_RUN);

    // output register; words before settling are withheld, not flagged
    always_ff @(posedge clk) begin
        if (!nrst) begin
            outWord_r    <= '0;
            outSettled_r <= 1'b0;
        end else begin
            outSettled_r    <= (seqState_r == SEQ_RUN);
            outWord_r.valid <= wordOut;
            if (wordOut) begin
                outWord_r.data <= postData;
            end
        end
    end

    assign outWord    = outWord_r;
    assign outSettled = outSettled_r;
    assign oscEnable  = oscEnable_r;
    assign seqCount   = rateCnt_r;

endmodule

// ### test/dfc_top_props.sv
// concurrent checks on the ports of the decimating filter chain
module dfc_top_props import dfc_pkg::*; #(
    parameter int MAC_BLOCKS     = DFC_MAC_BLOCKS,
    parameter int TAPS_PER_BLOCK = DFC_TAPS_PER_BLOCK
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       alignPin,
    input  wire logic       cfgStartPin,
    input  wire logic       oscillatorBypass,
    input  wire dfc_word_s  outWord,
    input  wire logic       outSettled,
    input  wire logic       oscEnable,
    input  wire logic [7:0] seqCount
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////////////
    // cycles since the last word; saturates so the slowest rate never wraps
    logic [11:0] gapCnt_r;
    always_ff @(posedge clk) begin
        if (!nrst || outWord.valid)
            gapCnt_r <= 12'h000;
        else if (gapCnt_r != 12'hfff)
            gapCnt_r <= gapCnt_r + 12'h001;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin paths pass three sync flops, so eight samples leave margin
    a_align_count: assert property (alignPin [*8] |-> seqCount == DFC_SEQ_RST)
        else $error("sequencer count not held during alignment");
    a_align_quiet: assert property (alignPin [*8] |-> !outWord.valid)
        else $error("word emitted during alignment");
    a_align_unsettle: assert property (alignPin [*8] |-> !outSettled)
        else $error("settled flag high during alignment");
    a_valid_settled: assert property (outWord.valid |-> outSettled)
        else $error("word flagged before settling");
    a_valid_pulse: assert property (outWord.valid |=> !outWord.valid)
        else $error("valid longer than one cycle");
    a_word_spacing: assert property (outWord.valid |-> gapCnt_r >= 12'h00f)
        else $error("words closer than sixteen clocks");
    a_data_update: assert property ($changed(outWord.data) |-> outWord.valid)
        else $error("output data changed without valid");
    a_osc_on: assert property (!oscillatorBypass [*8] |-> oscEnable)
        else $error("oscillator off with bypass low");
    a_osc_off: assert property (oscillatorBypass [*8] |-> !oscEnable)
        else $error("oscillator on with bypass high");
    a_cfg_aligns: assert property ($rose(cfgStartPin) |-> ##[1:8] !outSettled)
        else $error("configuration start did not align");

    c_word: cover property (outWord.valid);
    c_align: cover property (alignPin ##1 !alignPin);
    c_cfg: cover property ($rose(cfgStartPin));
endmodule

bind dfc_top dfc_top_props #(.MAC_BLOCKS(MAC_BLOCKS), .TAPS_PER_BLOCK(TAPS_PER_BLOCK)) u_dfc_top_props (.*);

// ### test/dfc_far_side.sv
// far-side model: modulator bit source and host word reader
module dfc_far_side import dfc_pkg::*; (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         negSel,
    input  wire dfc_word_s    outWord,
    input  wire logic         outSettled,
    output logic              modBit = 1'b1,
    output logic [15:0]       wordCount,
    output logic [DFC_DW-1:0] lastData,
    output logic [15:0]       lastGap
);
    logic [15:0] gapCnt;

    // modulator gives a steady dc level, one bit per master clock
    always @(posedge clk) modBit <= ~negSel;

    // reader drops words taken before settling; keeps spacing of accepted ones
    always @(posedge clk) begin
        if (!nrst) begin
            wordCount <= 16'h0000;
            gapCnt <= 16'h0000;
            lastGap <= 16'h0000;
            lastData <= DFC_DATA_RST;
        end else begin
            gapCnt <= gapCnt + 16'h0001;
            if (outWord.valid && outSettled) begin
                wordCount <= wordCount + 16'h0001;
                lastData <= outWord.data;
                lastGap <= gapCnt + 16'h0001;
                gapCnt <= 16'h0000;
            end
        end
    end
endmodule

// ### test/dfc_top_tb.sv
// self-checking bench of the decimating filter chain
module dfc_top_tb import dfc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    logic                  clk = 1'b0, nrst = 1'b0, nrstB = 1'b0, modBit, alignPin = 1'b0;
    logic                  cfgStartPin = 1'b0, oscillatorBypass = 1'b0, coefWrEn = 1'b0, negSel = 1'b0;
    logic [DFC_TAP_AW-1:0] coefWrAddr = 7'h00, tapCount = 7'h01;
    logic [DFC_DW-1:0]     coefWrData = 24'h000000, fbCoef = 24'h000000, lastData;
    logic [DFC_RATE_W-1:0] rateFactor = 9'h002;
    dfc_mode_e             postMode = DFC_MODE_FIR;
    dfc_word_s             outWord, outWordB;
    logic                  outSettled, oscEnable;
    logic [7:0]            seqCount;
    logic [15:0]           wordCount, lastGap;
    int                    fails = 0, nChecks = 0, cycles = 0;

    dfc_top u_dfc_top (.*);
    dfc_top u_dfc_top_b (.*, .nrst(nrstB), .outWord(outWordB), .outSettled(), .oscEnable(), .seqCount());
    dfc_far_side u_dfc_far_side (.*);

    ////////////////////////////////////////////////////////////////////////////////
    // master clock never stops; the cycle ceiling cuts a hang short
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            report_and_stop();
        end
    end

    task report_and_stop;
        if (fails == 0 && nChecks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task chk(input string what, input logic [23:0] expv, input logic [23:0] got);
        nChecks++;
        if (got !== expv) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, expv, got);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task wr_coef(input logic [6:0] a, input logic [23:0] d);
        @(posedge clk);
        coefWrEn <= 1'b1;
        coefWrAddr <= a;
        coefWrData <= d;
        @(posedge clk);
        coefWrEn <= 1'b0;
    endtask

    // one clock long strobe, as a controller of several devices may send
    task align;
        @(posedge clk);
        alignPin <= 1'b1;
        @(posedge clk);
        alignPin <= 1'b0;
        // return once the strobe has passed the synchroniser, so no older word is counted after
        tick(4);
    endtask

    // bounded wait for n more accepted words
    task wait_words(input int n);
        int start, k;
        start = wordCount;
        k = 0;
        while (wordCount < start + n && k < 9000) begin
            @(posedge clk);
            #1 k++;
        end
        chk("word arrival", 24'h1, 24'(k < 9000));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task t_dual;
        int diff;
        diff = 0;
        align;
        repeat (400) begin
            @(posedge clk);
            #1 if (outWord.valid !== outWordB.valid) diff++;
        end
        chk("paired valids", 24'h0, 24'(diff));
    endtask

    task t_dc_fir;
        wr_coef(7'h00, DFC_MOD_POS);
        align;
        wait_words(3);
        chk("fir dc plus", DFC_MOD_POS, lastData);
        @(posedge clk);
        negSel <= 1'b1;
        wait_words(10);
        chk("fir dc minus", DFC_MOD_NEG, lastData);
        @(posedge clk);
        negSel <= 1'b0;
    endtask

    task t_rates;
        logic [8:0] rs [5] = '{9'h000, 9'h002, 9'h003, 9'h100, 9'h12c};
        int ex [5] = '{2, 2, 3, 256, 256};
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            rateFactor <= rs[i];
            align;
            wait_words(2);
            chk("word spacing", 24'(8 * ex[i]), {8'h00, lastGap});
        end
        @(posedge clk);
        rateFactor <= 9'h002;
        align;
        wait_words(2);
    endtask

    task t_align;
        int k;
        @(posedge clk);
        alignPin <= 1'b1;
        tick(8);
        #1 chk("count in alignment", 24'h0, {16'h0000, seqCount});
        chk("settled in alignment", 24'h0, 24'(outSettled));
        @(posedge clk);
        alignPin <= 1'b0;
        k = 0;
        while (outWord.valid !== 1'b1 && k < 200) begin
            @(posedge clk);
            #1 k++;
        end
        chk("resume delay", 24'h1, 24'(k >= 40 && k < 120));
    endtask

    task t_cfg;
        int k;
        @(posedge clk);
        cfgStartPin <= 1'b1;
        k = 0;
        while (outSettled !== 1'b0 && k < 12) begin
            @(posedge clk);
            #1 k++;
        end
        chk("start aligns", 24'h1, 24'(k < 12));
        wait_words(2);
        @(posedge clk);
        cfgStartPin <= 1'b0;
    endtask

    // last tap index usable, one beyond it ignored
    task t_taps;
        wr_coef(7'h00, DFC_DATA_RST);
        wr_coef(7'h6b, DFC_MOD_POS);
        wr_coef(7'h6c, 24'h7fffff);
        @(posedge clk);
        tapCount <= 7'h6c;
        align;
        wait_words(3);
        chk("tap 107 only", DFC_MOD_POS, lastData);
        wr_coef(7'h6b, DFC_DATA_RST);
        wr_coef(7'h00, DFC_MOD_POS);
        @(posedge clk);
        tapCount <= 7'h01;
        // partial sums of the long filter drain through the chain before later checks
        wait_words(60);
    endtask

    task t_modes;
        @(posedge clk);
        fbCoef <= 24'h080000;
        postMode <= DFC_MODE_POLY;
        align;
        wait_words(3);
        chk("polynomial", 24'h180000, lastData);
        @(posedge clk);
        postMode <= DFC_MODE_IIR;
        align;
        wait_words(40);
        chk("recursive", 24'h1, 24'(lastData >= 24'h1fff00 && lastData <= 24'h200000));
        @(posedge clk);
        postMode <= DFC_MODE_FIR;
    endtask

    task t_osc;
        @(posedge clk);
        oscillatorBypass <= 1'b1;
        tick(8);
        #1 chk("osc bypassed", 24'h0, 24'(oscEnable));
        @(posedge clk);
        oscillatorBypass <= 1'b0;
        tick(8);
        #1 chk("osc running", 24'h1, 24'(oscEnable));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // second device leaves reset later so only alignment can pair them
    initial begin
        tick(15);
        #1 chk("osc in reset", 24'h1, 24'(oscEnable));
        @(posedge clk);
        nrst <= 1'b1;
        tick(5);
        nrstB <= 1'b1;
        tick(10);
        t_dual();
        t_dc_fir();
        t_rates();
        t_align();
        t_cfg();
        t_taps();
        t_modes();
        t_osc();
        report_and_stop();
    end
endmodule
